// file: verilog/brd_pkg.sv
// constants for the baud rate and divider timer block
// Contract
// - variable-rate UART baud equals 2^doubling*pclk/(32*2*(256-high byte reload)).
// - mode select at 1 makes the divider a normal divider, fractional baud off.
// - enabled normal divider is an 8-bit auto-reload counter counting up from reload.
// - result register shows the counter value; reload register supplies the reload value.
// - every normal-divider overflow sets the overflow flag and requests an interrupt. Here irq only rises while irq_mask is 1, and irq_mask resets to 0.
// - divider output clock is input clock divided by (256 minus reload value).
package brd_pkg;
   localparam logic [7:0]  ADDR_CTRL    = 8'h00; // divider_control_reg
   localparam logic [7:0]  ADDR_RELOAD  = 8'h04; // divider_reload_reg
   localparam logic [7:0]  ADDR_RESULT  = 8'h08; // divider_result_reg, read only
   localparam logic [7:0]  ADDR_THIGH   = 8'h0C; // baud_timer_high_byte
   localparam logic [7:0]  ADDR_MASK    = 8'h10; // interrupt mask
   localparam logic [7:0]  ADDR_BAUD    = 8'h14; // baud timer control
   localparam int          CTRL_EN_BIT  = 0;     // divider_enable
   localparam int          CTRL_MS_BIT  = 1;     // divider_mode_select
   localparam int          CTRL_OV_BIT  = 2;     // normal_divider_overflow_flag, write 1 clears
   localparam int          BAUD_RUN_BIT = 0;     // baud timer run
   localparam int          BAUD_DBL_BIT = 1;     // baud_doubling_bit
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [7:0]  CNT_TOP      = 8'hFF;
   localparam logic [4:0]  BAUD_DIV32   = 5'h1F; // 32 overflows per bit
   localparam logic [4:0]  BAUD_DIV16   = 5'h0F; // 16 overflows per bit when doubled
   localparam logic [31:0] RST_WORD     = 32'h00000000;
endpackage : brd_pkg

// file: verilog/brd_reload_counter.sv
// 8-bit auto-reload up counter with overflow pulse
`timescale 1ns/1ps
module brd_reload_counter (
   input  wire logic       pclk,    // clock
   input  wire logic       presetn, // async reset, active low
   input  wire logic       run,     // counting allowed
   input  wire logic       tick,    // input clock pulse
   input  wire logic [7:0] reload,  // reload value
   output logic      [7:0] count,   // current value
   output logic            ovf      // overflow pulse
);
   logic [7:0] next_count;

   assign ovf = run & tick & (count == brd_pkg::CNT_TOP);
   // idle counter sits at reload so the first period is full length
   assign next_count = !run ? reload :
                       ovf  ? reload :
                       tick ? count + 8'h01 : count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) count <= brd_pkg::RST_BYTE;
      else          count <= next_count;
   end

   chk_reload_on_ovf: assert property (@(posedge pclk) disable iff (!presetn)
      ovf |=> count == $past(reload))
      else $error("counter did not reload after overflow");
   chk_count_up: assert property (@(posedge pclk) disable iff (!presetn)
      run && tick && count != brd_pkg::CNT_TOP |=> count == $past(count) + 8'h01)
      else $error("counter did not step by one");
endmodule : brd_reload_counter

// file: verilog/brd_top.sv
// baud timer and normal divider with apb registers and interrupt
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module brd_top (
   input  wire logic        pclk,                  // 40 MHz peripheral clock
   input  wire logic        presetn,               // async reset, active low
   input  wire logic        psel,                  // apb select
   input  wire logic        penable,               // apb access phase
   input  wire logic        pwrite,                // apb direction
   input  wire logic [7:0]  paddr,                 // apb byte address
   input  wire logic [31:0] pwdata,                // apb write data
   output logic      [31:0] prdata,                // apb read data
   output logic             pready,                // apb ready
   output logic             pslverr,               // apb error, unmapped address
   output logic             irq,                   // level interrupt
   output logic             baud_tick,             // one pulse per uart bit time
   output logic             divider_output_clock,  // one pulse per divider overflow
   output logic             frac_baud_en           // fractional baud path allowed
);
   logic [7:0] reload_reg;
   logic [7:0] thigh_reg;
   logic       div_en;
   logic       mode_sel;
   logic       normal_divider_overflow_flag;
   logic       irq_mask;
   logic       baud_run;
   logic       baud_dbl;
   logic       tmr_tick;
   logic [4:0] baud_sub;
   logic [7:0] div_count;
   logic       div_ovf;
   logic       tmr_ovf;
   logic       div_pulse;
   logic [7:0] tmr_count;

   wire setup    = psel & ~penable;
   wire wr       = psel & penable & pwrite;
   wire hit_ctrl = paddr == brd_pkg::ADDR_CTRL;
   wire hit_rel  = paddr == brd_pkg::ADDR_RELOAD;
   wire hit_res  = paddr == brd_pkg::ADDR_RESULT;
   wire hit_th   = paddr == brd_pkg::ADDR_THIGH;
   wire hit_mask = paddr == brd_pkg::ADDR_MASK;
   wire hit_baud = paddr == brd_pkg::ADDR_BAUD;
   wire mapped   = hit_ctrl | hit_rel | hit_res | hit_th | hit_mask | hit_baud;
   wire div_run  = div_en & mode_sel;
   wire [4:0] baud_last = baud_dbl ? brd_pkg::BAUD_DIV16 : brd_pkg::BAUD_DIV32;
   wire normal_divider_overflow_flag_clr = wr & hit_ctrl & pwdata[brd_pkg::CTRL_OV_BIT];

   wire [31:0] rd_mux =
      hit_ctrl ? {29'h0, normal_divider_overflow_flag, mode_sel, div_en} :
      hit_rel  ? {24'h0, reload_reg} :
      hit_res  ? {24'h0, div_count} :
      hit_th   ? {24'h0, thigh_reg} :
      hit_mask ? {31'h0, irq_mask} :
      hit_baud ? {30'h0, baud_dbl, baud_run} : brd_pkg::RST_WORD;

   // zero wait states; read data is captured in the setup cycle so it comes from a flop
   assign pready       = 1'b1;
   assign pslverr      = psel & penable & ~mapped;
   assign irq          = normal_divider_overflow_flag & irq_mask;
   assign frac_baud_en = div_en & ~mode_sel;
   assign divider_output_clock = div_pulse;
   assign baud_tick    = tmr_ovf & (baud_sub == baud_last);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= brd_pkg::RST_WORD;
      else if (setup && !pwrite) prdata <= rd_mux;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_en   <= 1'b0;
         mode_sel <= 1'b0;
         irq_mask <= 1'b0;
         baud_run <= 1'b0;
         baud_dbl <= 1'b0;
      end else if (wr) begin
         if (hit_ctrl) div_en   <= pwdata[brd_pkg::CTRL_EN_BIT];
         if (hit_ctrl) mode_sel <= pwdata[brd_pkg::CTRL_MS_BIT];
         if (hit_mask) irq_mask <= pwdata[0];
         if (hit_baud) baud_run <= pwdata[brd_pkg::BAUD_RUN_BIT];
         if (hit_baud) baud_dbl <= pwdata[brd_pkg::BAUD_DBL_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_reg <= brd_pkg::RST_BYTE;
         thigh_reg  <= brd_pkg::RST_BYTE;
      end else if (wr) begin
         if (hit_rel) reload_reg <= pwdata[7:0];
         if (hit_th)  thigh_reg  <= pwdata[7:0];
      end
   end

   // an overflow in the clearing cycle must not be lost, so set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)     normal_divider_overflow_flag <= 1'b0;
      else if (div_ovf) normal_divider_overflow_flag <= 1'b1;
      else if (normal_divider_overflow_flag_clr) normal_divider_overflow_flag <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_pulse <= 1'b0;
      else          div_pulse <= div_ovf;
   end

   // the baud timer counts at half the peripheral clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)      tmr_tick <= 1'b0;
      else if (baud_run) tmr_tick <= ~tmr_tick;
      else               tmr_tick <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)       baud_sub <= 5'h00;
      else if (!baud_run) baud_sub <= 5'h00;
      else if (baud_tick) baud_sub <= 5'h00;
      else if (tmr_ovf)   baud_sub <= baud_sub + 5'h01;
   end

   brd_reload_counter u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (div_run),
      .tick    (1'b1),
      .reload  (reload_reg),
      .count   (div_count),
      .ovf     (div_ovf)
   );

   brd_reload_counter u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (baud_run),
      .tick    (tmr_tick),
      .reload  (thigh_reg),
      .count   (tmr_count),
      .ovf     (tmr_ovf)
   );

   // helper: cycles since the last overflow with unchanged configuration
   logic [8:0] gap;
   logic       gap_ok;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap    <= 9'h000;
         gap_ok <= 1'b0;
      end else if (!div_run || (wr && (hit_rel || hit_ctrl))) begin
         gap    <= 9'h000;
         gap_ok <= 1'b0;
      end else if (div_ovf) begin
         gap    <= 9'h000;
         gap_ok <= 1'b1;
      end else begin
         gap    <= gap + 9'h001;
      end
   end

   sequence s_ovf_flag;
      div_ovf ##1 (normal_divider_overflow_flag && divider_output_clock);
   endsequence

   chk_ovf_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      div_ovf |-> s_ovf_flag)
      else $error("overflow did not set flag and output pulse");
   chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      div_ovf && irq_mask && !(wr && hit_mask) |=> irq)
      else $error("unmasked overflow raised no interrupt");
   chk_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !div_run |-> !div_ovf && (!mode_sel || !frac_baud_en))
      else $error("divider ran outside normal divider mode");
   chk_result_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_res |=> prdata[7:0] == $past(div_count))
      else $error("result register does not show counter");
   chk_div_period: assert property (@(posedge pclk) disable iff (!presetn)
      div_ovf && gap_ok |-> gap == {1'b0, 8'hFF - reload_reg})
      else $error("divider period is not 256 minus reload");
   chk_timer_half: assert property (@(posedge pclk) disable iff (!presetn)
      tmr_tick |=> !tmr_tick)
      else $error("baud timer ticks faster than half clock");
   chk_baud_src: assert property (@(posedge pclk) disable iff (!presetn)
      baud_tick |-> tmr_ovf &&
         baud_sub == (baud_dbl ? brd_pkg::BAUD_DIV16 : brd_pkg::BAUD_DIV32))
      else $error("baud tick not on the right timer overflow");

   // a one written to the flag clears it only when no overflow lands in that cycle
   sequence s_flag_clear;
      normal_divider_overflow_flag_clr && !div_ovf ##1 !normal_divider_overflow_flag;
   endsequence

   // the baud timer steps on every second clock while it runs
   sequence s_tick_gap;
      baud_run && !tmr_tick ##1 baud_run;
   endsequence

   chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
      normal_divider_overflow_flag_clr && !div_ovf |-> s_flag_clear)
      else $error("written one did not clear the overflow flag");
   chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      !div_ovf && !normal_divider_overflow_flag_clr |=> normal_divider_overflow_flag == $past(normal_divider_overflow_flag))
      else $error("overflow flag changed without overflow or clear");
   chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
      !irq_mask |-> !irq)
      else $error("masked overflow raised an interrupt");

   chk_pulse_only_ovf: assert property (@(posedge pclk) disable iff (!presetn)
      divider_output_clock |-> $past(div_ovf))
      else $error("divider output pulse without overflow");
   chk_result_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !div_run |=> div_count == $past(reload_reg))
      else $error("stopped divider does not sit at the reload value");

   chk_timer_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !baud_run |=> tmr_count == $past(thigh_reg))
      else $error("stopped baud timer does not sit at the high byte");
   chk_timer_rate: assert property (@(posedge pclk) disable iff (!presetn)
      s_tick_gap |-> tmr_tick)
      else $error("baud timer missed its every second clock step");
   chk_baud_needs_run: assert property (@(posedge pclk) disable iff (!presetn)
      !baud_run |-> !baud_tick)
      else $error("baud tick while the baud timer is stopped");
endmodule : brd_top

// file: testbench/brd_uart_model.sv
// uart side model: measures cycles between consecutive clock pulses
`timescale 1ns/1ps
module brd_uart_model (
   input  wire logic pclk,    // clock
   input  wire logic presetn, // async reset, active low
   input  wire logic tick,    // pulse to time
   output int        period,  // cycles between the last two pulses
   output int        pulses   // pulses seen
);
   int cyc;
   int last;
   // every pulse restarts the interval; a lone first pulse gives a bogus period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc <= 0;
         last <= 0;
         period <= 0;
         pulses <= 0;
      end else begin
         cyc <= cyc + 1;
         if (tick) begin
            period <= cyc - last;
            last <= cyc;
            pulses <= pulses + 1;
         end
      end
   end
endmodule : brd_uart_model

// file: testbench/testbench.sv
// self-checking bench for the baud timer and normal divider
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("FAIL %s exp %0h got %0h", n, e, g); end end
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, q;
   logic pready, pslverr, irq, baud_tick, divider_output_clock, frac_baud_en, err;
   logic [15:0] seed = 16'h3B38;
   logic [7:0] rl, hb;
   int bad_count = 0, samples_checked = 0, bper, dper, bn, dn, dn0;
   brd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .baud_tick(baud_tick),
      .divider_output_clock(divider_output_clock), .frac_baud_en(frac_baud_en));
   brd_uart_model i_uart (.pclk(pclk), .presetn(presetn), .tick(baud_tick),
      .period(bper), .pulses(bn));
   brd_uart_model i_divmon (.pclk(pclk), .presetn(presetn), .tick(divider_output_clock),
      .period(dper), .pulses(dn));
   always #12.5 pclk = ~pclk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // divider period in clocks: 256 minus the step value
   function automatic int exp_div(input logic [7:0] step);
      return 256 - step;
   endfunction : exp_div
   // bit time in clocks: 32 * 2 * (256 - high byte), halved per doubling
   function automatic int exp_baud(input logic [7:0] hi, input int dbl);
      return 64 * (256 - hi) / (1 << dbl);
   endfunction : exp_baud
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wrap_up();
      if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   initial begin
      #(25 * 80000);
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a <= 8'h14; a += 4) begin
         apb(1'b0, 8'(a), 32'h0);
         `CHK("reset value", 32'h00000000, q)
         `CHK("mapped no error", 1'b0, err)
      end
      apb(1'b0, 8'h18, 32'h0);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped read", 32'h00000000, q)
      apb(1'b1, brd_pkg::ADDR_MASK, 32'h1);
      // corner reloads first: period 1 and the full 256
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         rl = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
         apb(1'b1, brd_pkg::ADDR_RELOAD, {24'h0, rl});
         apb(1'b1, brd_pkg::ADDR_CTRL, 32'h7);
         @(negedge pclk);
         `CHK("fractional path", 1'b0, frac_baud_en)
         repeat (3 * exp_div(rl) + 4) @(posedge pclk);
         `CHK("divider period", exp_div(rl), dper)
         `CHK("overflow irq", 1'b1, irq)
         apb(1'b1, brd_pkg::ADDR_MASK, 32'h0);
         @(negedge pclk);
         `CHK("masked irq", 1'b0, irq)
         apb(1'b1, brd_pkg::ADDR_MASK, 32'h1);
         apb(1'b0, brd_pkg::ADDR_CTRL, 32'h0);
         `CHK("overflow flag", 1'b1, q[brd_pkg::CTRL_OV_BIT])
         apb(1'b0, brd_pkg::ADDR_RESULT, 32'h0);
         `CHK("result range", 1'b1, q[7:0] >= rl)
         apb(1'b0, brd_pkg::ADDR_RELOAD, 32'h0);
         `CHK("reload readback", rl, q[7:0])
         // stop first, then clear: a last overflow would win over the clear
         apb(1'b1, brd_pkg::ADDR_CTRL, 32'h2);
         apb(1'b1, brd_pkg::ADDR_CTRL, 32'h6);
         @(posedge pclk);
         `CHK("irq cleared", 1'b0, irq)
         dn0 = dn;
         repeat (20) @(posedge pclk);
         `CHK("stopped divider", dn0, dn)
      end
      apb(1'b1, brd_pkg::ADDR_CTRL, 32'h1);
      @(negedge pclk);
      `CHK("fractional path", 1'b1, frac_baud_en)
      apb(1'b1, brd_pkg::ADDR_CTRL, 32'h0);
      // baud timer always auto-reload, high byte set first then run
      for (int d = 0; d < 2; d++) begin
         seed = lfsr(seed);
         hb = {4'hF, seed[3:0]};
         apb(1'b1, brd_pkg::ADDR_THIGH, {24'h0, hb});
         apb(1'b1, brd_pkg::ADDR_BAUD, {30'h0, d[0], 1'b1});
         repeat (3 * exp_baud(hb, d) + 8) @(posedge pclk);
         `CHK("baud period", exp_baud(hb, d), bper)
         apb(1'b1, brd_pkg::ADDR_BAUD, 32'h0);
      end
      wrap_up();
   end
endmodule : testbench
